// ### hw/dsg_clock_gate.sv
`timescale 1ns/1ns
`default_nettype none
module dsg_clock_gate
(
  input  wire logic                            clk_i,                // System clock, 125 MHz
  input  wire logic                            rst_i,                // Synchronous reset, active high
  input  wire logic [dsg_pkg::DSG_AW-1:0]      wb_adr_i,             // Wishbone byte address
  input  wire logic [dsg_pkg::DSG_DW-1:0]      wb_dat_i,             // Wishbone write data
  input  wire logic [3:0]                      wb_sel_i,             // Wishbone byte selects
  input  wire logic                            wb_we_i,              // Wishbone write enable
  input  wire logic                            wb_cyc_i,             // Wishbone cycle
  input  wire logic                            wb_stb_i,             // Wishbone strobe
  output logic      [dsg_pkg::DSG_DW-1:0]      wb_dat_o,             // Wishbone read data
  output logic                                 wb_ack_o,             // Wishbone acknowledge
  input  wire logic                            sleep_i,              // System in sleep
  input  wire logic                            deep_sleep_i,         // System in deep-sleep
  input  wire logic [dsg_pkg::DSG_DW-1:0]      run_gate_group1_i,    // Run-mode enables
  input  wire logic [dsg_pkg::DSG_DW-1:0]      sleep_gate_group1_i,  // Sleep-mode enables
  input  wire logic [dsg_pkg::DSG_NUNITS-1:0]  unit_req_i,           // Access aimed at each unit
  output logic      [dsg_pkg::DSG_NUNITS-1:0]  unit_clk_en_o,        // Clock enable per unit
  output logic      [dsg_pkg::DSG_NUNITS-1:0]  unit_fault_o,         // Bus fault pulse per unit
  output logic                                 irq_o                 // Fault interrupt, level
);
  import dsg_pkg::*;

  logic [DSG_DW-1:0]     gate_ff;
  logic [DSG_DW-1:0]     cfg_ff;
  logic [DSG_DW-1:0]     stat_ff;
  logic [DSG_DW-1:0]     mask_ff;
  logic [DSG_DW-1:0]     rdat_ff;
  logic                  ack_ff;
  logic                  irq_ff;
  logic [DSG_DW-1:0]     nxt_gate;
  logic [DSG_DW-1:0]     nxt_cfg;
  logic [DSG_DW-1:0]     nxt_stat;
  logic [DSG_DW-1:0]     nxt_mask;
  logic [DSG_DW-1:0]     nxt_rdat;
  logic                  nxt_ack;
  logic                  nxt_irq;
  logic [DSG_DW-1:0]     byte_mask;
  logic [DSG_DW-1:0]     wr_bits;
  logic                  wr_commit;
  logic                  auto_gating_select;
  dsg_mode_type          gate_mode;
  logic [DSG_NUNITS-1:0] sel_units;
  logic [DSG_NUNITS-1:0] deep_units;
  logic [DSG_NUNITS-1:0] sleep_units;
  logic [DSG_NUNITS-1:0] run_units;
  logic [DSG_NUNITS-1:0] unit_clk_en;
  logic [DSG_NUNITS-1:0] unit_fault;

  assign auto_gating_select = cfg_ff[DSG_POS_AUTO_GATING];
  assign deep_units         = dsg_pack_units(gate_ff);
  assign sleep_units        = dsg_pack_units(sleep_gate_group1_i);
  assign run_units          = dsg_pack_units(run_gate_group1_i);

  // Mode selection: without auto gating the run-mode enables always apply
  always_comb begin
    if (auto_gating_select && deep_sleep_i) begin
      gate_mode = DSG_MODE_DEEP;
    end else if (auto_gating_select && sleep_i) begin
      gate_mode = DSG_MODE_SLEEP;
    end else begin
      gate_mode = DSG_MODE_RUN;
    end
    case (gate_mode)
      DSG_MODE_DEEP:  sel_units = deep_units;
      DSG_MODE_SLEEP: sel_units = sleep_units;
      default:        sel_units = run_units;
    endcase
  end

  generate
    for (genvar g = 0; g < DSG_NUNITS; g++) begin : g_unit
      dsg_unit_gate u_gate (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .en_i     (sel_units[g]),
        .req_i    (unit_req_i[g]),
        .clk_en_o (unit_clk_en[g]),
        .fault_o  (unit_fault[g])
      );
    end
  endgenerate

  // Register bus: ack one cycle after the request, write lands on the acked edge
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      byte_mask[8*b +: 8] = {8{wb_sel_i[b]}};
    end
    nxt_ack   = wb_cyc_i & wb_stb_i & ~ack_ff;
    wr_commit = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
    wr_bits   = wb_dat_i & byte_mask;
    nxt_gate  = gate_ff;
    nxt_cfg   = cfg_ff;
    nxt_mask  = mask_ff;
    nxt_stat  = stat_ff;
    if (wr_commit) begin
      if (wb_adr_i == DSG_OFF_DEEP_GATE) begin
        // Only the seven enable bits take writes; reserved stay zero
        nxt_gate = ((gate_ff & ~byte_mask) | wr_bits) & DSG_GATE_WMASK;
      end else if (wb_adr_i == DSG_OFF_RUN_CFG) begin
        nxt_cfg = ((cfg_ff & ~byte_mask) | wr_bits) & DSG_CFG_WMASK;
      end else if (wb_adr_i == DSG_OFF_FLT_MASK) begin
        nxt_mask = ((mask_ff & ~byte_mask) | wr_bits) & DSG_GATE_WMASK;
      end else if (wb_adr_i == DSG_OFF_FLT_STAT) begin
        nxt_stat = stat_ff & ~wr_bits;
      end
    end
    // A fault in the clearing cycle is kept: set wins over clear
    nxt_stat = nxt_stat | dsg_spread_units(unit_fault);
    nxt_irq  = |(nxt_stat & nxt_mask);
    nxt_rdat = rdat_ff;
    if (nxt_ack) begin
      if (wb_adr_i == DSG_OFF_DEEP_GATE) begin
        nxt_rdat = gate_ff & DSG_GATE_WMASK;
      end else if (wb_adr_i == DSG_OFF_RUN_CFG) begin
        nxt_rdat = cfg_ff;
      end else if (wb_adr_i == DSG_OFF_FLT_STAT) begin
        nxt_rdat = stat_ff;
      end else if (wb_adr_i == DSG_OFF_FLT_MASK) begin
        nxt_rdat = mask_ff;
      end else if (wb_adr_i == DSG_OFF_EFF_GATE) begin
        nxt_rdat = dsg_spread_units(unit_clk_en);
      end else begin
        nxt_rdat = '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_ff <= DSG_GATE_RST;
      cfg_ff  <= DSG_CFG_RST;
      stat_ff <= DSG_STAT_RST;
      mask_ff <= DSG_MASK_RST;
      rdat_ff <= '0;
      ack_ff  <= 1'b0;
      irq_ff  <= 1'b0;
    end else begin
      gate_ff <= nxt_gate;
      cfg_ff  <= nxt_cfg;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      rdat_ff <= nxt_rdat;
      ack_ff  <= nxt_ack;
      irq_ff  <= nxt_irq;
    end
  end

  assign wb_dat_o      = rdat_ff;
  assign wb_ack_o      = ack_ff;
  assign irq_o         = irq_ff;
  assign unit_clk_en_o = unit_clk_en;
  assign unit_fault_o  = unit_fault;

  AST_ACK_NEXT: assert property (
    @(posedge clk_i) disable iff (rst_i) (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("no ack one cycle after request");

  AST_ACK_SINGLE: assert property (
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  AST_RESET_CLEAR: assert property (
    @(posedge clk_i) disable iff (rst_i) $fell(rst_i) |-> (gate_ff == '0) && (unit_clk_en_o == '0))
    else $error("gate register not zero after reset");

  AST_RSVD_ZERO: assert property (
    @(posedge clk_i) disable iff (rst_i) (gate_ff & ~DSG_GATE_WMASK) == '0)
    else $error("reserved gate bit set");

  AST_GATE_WRITE: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i == 4'hf && wb_adr_i == DSG_OFF_DEEP_GATE)
      |=> gate_ff == ($past(wb_dat_i) & DSG_GATE_WMASK))
    else $error("gate write not stored");

  AST_DEEP_SELECT: assert property (
    @(posedge clk_i) disable iff (rst_i) (auto_gating_select && deep_sleep_i) |=> unit_clk_en_o == $past(deep_units))
    else $error("deep-sleep enables not applied");

  AST_RUN_SELECT: assert property (
    @(posedge clk_i) disable iff (rst_i) !auto_gating_select |=> unit_clk_en_o == $past(run_units))
    else $error("run enables not applied without auto gating");

  AST_IRQ_LEVEL: assert property (
    @(posedge clk_i) disable iff (rst_i) irq_o == |(stat_ff & mask_ff))
    else $error("interrupt level disagrees with status and mask");

  AST_FAULT_STICKY: assert property (
    @(posedge clk_i) disable iff (rst_i) (unit_fault_o[0]) |=> stat_ff[DSG_POS_ASYNC0])
    else $error("fault not recorded in status");

  COV_DEEP_CLOCKED: cover property (
    @(posedge clk_i) disable iff (rst_i) auto_gating_select && deep_sleep_i ##1 (unit_clk_en_o != '0));

  COV_FAULT: cover property (
    @(posedge clk_i) disable iff (rst_i) |unit_fault_o);

  COV_IRQ: cover property (
    @(posedge clk_i) disable iff (rst_i) $rose(irq_o));

endmodule : dsg_clock_gate
`default_nettype wire

// ### hw/dsg_pkg.sv
package dsg_pkg;

  localparam int DSG_DW     = 32;
  localparam int DSG_AW     = 12;
  localparam int DSG_NUNITS = 7;

  // Byte addresses of the registers
  localparam logic [DSG_AW-1:0] DSG_OFF_RUN_CFG   = 12'h060;
  localparam logic [DSG_AW-1:0] DSG_OFF_DEEP_GATE = 12'h124;
  localparam logic [DSG_AW-1:0] DSG_OFF_FLT_STAT  = 12'h130;
  localparam logic [DSG_AW-1:0] DSG_OFF_FLT_MASK  = 12'h134;
  localparam logic [DSG_AW-1:0] DSG_OFF_EFF_GATE  = 12'h138;

  // Unit enable positions inside the gate register, then the auto gating bit of the config register
  localparam int DSG_POS_ASYNC0 = 0;
  localparam int DSG_POS_ASYNC1 = 1;
  localparam int DSG_POS_SYNC0  = 4;
  localparam int DSG_POS_TMR0   = 16;
  localparam int DSG_POS_TMR1   = 17;
  localparam int DSG_POS_TMR2   = 18;
  localparam int DSG_POS_CMP0   = 24;
  localparam int DSG_UNIT_POS [DSG_NUNITS] = '{DSG_POS_ASYNC0, DSG_POS_ASYNC1, DSG_POS_SYNC0,
                                               DSG_POS_TMR0, DSG_POS_TMR1, DSG_POS_TMR2, DSG_POS_CMP0};
  localparam int DSG_POS_AUTO_GATING = 27;

  localparam logic [DSG_DW-1:0] DSG_GATE_RST    = 32'h0000_0000;
  localparam logic [DSG_DW-1:0] DSG_GATE_WMASK  = 32'h0107_0013;
  localparam logic [DSG_DW-1:0] DSG_CFG_RST     = 32'h0000_0000;
  localparam logic [DSG_DW-1:0] DSG_CFG_WMASK   = 32'h0800_0000;
  localparam logic [DSG_DW-1:0] DSG_STAT_RST    = 32'h0000_0000;
  localparam logic [DSG_DW-1:0] DSG_MASK_RST    = 32'h0000_0000;

  typedef enum logic [1:0] {
    DSG_MODE_RUN   = 2'b00,
    DSG_MODE_SLEEP = 2'b01,
    DSG_MODE_DEEP  = 2'b10
  } dsg_mode_type;

  // Gather the per-unit bits of a register in gate layout
  function automatic logic [DSG_NUNITS-1:0] dsg_pack_units(input logic [DSG_DW-1:0] r);
    logic [DSG_NUNITS-1:0] u;
    u = '0;
    for (int i = 0; i < DSG_NUNITS; i++) begin
      u[i] = r[DSG_UNIT_POS[i]];
    end
    return u;
  endfunction : dsg_pack_units

  // Spread per-unit bits back to gate layout
  function automatic logic [DSG_DW-1:0] dsg_spread_units(input logic [DSG_NUNITS-1:0] u);
    logic [DSG_DW-1:0] r;
    r = '0;
    for (int i = 0; i < DSG_NUNITS; i++) begin
      r[DSG_UNIT_POS[i]] = u[i];
    end
    return r;
  endfunction : dsg_spread_units

endpackage : dsg_pkg

// ### hw/dsg_unit_gate.sv
`timescale 1ns/1ns
`default_nettype none
module dsg_unit_gate (
  input  wire logic clk_i,      // System clock
  input  wire logic rst_i,      // Synchronous reset, active high
  input  wire logic en_i,       // Selected enable for this unit
  input  wire logic req_i,      // Bus access aimed at this unit
  output logic      clk_en_o,   // Clock enable to the unit
  output logic      fault_o     // One-cycle bus fault pulse
);
  logic clk_en_ff;
  logic fault_ff;
  logic nxt_clk_en;
  logic nxt_fault;

  always_comb begin
    nxt_clk_en = en_i;
    // The unit cannot answer while its clock is withheld
    nxt_fault  = req_i & ~clk_en_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_en_ff <= 1'b0;
      fault_ff  <= 1'b0;
    end else begin
      clk_en_ff <= nxt_clk_en;
      fault_ff  <= nxt_fault;
    end
  end

  assign clk_en_o = clk_en_ff;
  assign fault_o  = fault_ff;

  AST_FAULT_WHEN_GATED: assert property (
    @(posedge clk_i) disable iff (rst_i) (req_i && !clk_en_o) |=> fault_o)
    else $error("access to unclocked unit gave no fault");

  AST_NO_FAULT_WHEN_CLOCKED: assert property (
    @(posedge clk_i) disable iff (rst_i) fault_o |-> !$past(clk_en_o) && $past(req_i))
    else $error("fault raised without a gated access");

  AST_CLOCK_WITHHELD: assert property (
    @(posedge clk_i) disable iff (rst_i) (!en_i ##1 !en_i) |-> !clk_en_o)
    else $error("clock enable high while unit enable is low");

endmodule : dsg_unit_gate
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dsg_pkg::*;
  logic                  clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, irq_o;
  logic                  sleep_i, deep_sleep_i;
  logic [DSG_AW-1:0]     wb_adr_i;
  logic [DSG_DW-1:0]     wb_dat_i, wb_dat_o, run_gate_group1_i, sleep_gate_group1_i, rd;
  logic [3:0]            wb_sel_i;
  logic [DSG_NUNITS-1:0] unit_req_i, unit_clk_en_o, unit_fault_o;
  int                    err_count, n_compared;
  int                    cyc_cnt = 0;
  logic [1:0]            mode_tab [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
  logic [6:0]            exp_tab  [4] = '{7'h40, 7'h08, 7'h04, 7'h04};

  dsg_clock_gate u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_i(sleep_i), .deep_sleep_i(deep_sleep_i),
    .run_gate_group1_i(run_gate_group1_i), .sleep_gate_group1_i(sleep_gate_group1_i),
    .unit_req_i(unit_req_i), .unit_clk_en_o(unit_clk_en_o), .unit_fault_o(unit_fault_o),
    .irq_o(irq_o));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // Bounded run: the whole sequence needs well under a thousand cycles
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Classic single cycle; idle cycle follows because the next call waits an edge first
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic req(input int u, input logic [6:0] exp_fault);
    @(posedge clk_i);
    unit_req_i <= 7'h01 << u;
    @(posedge clk_i);
    unit_req_i <= '0;
    #1;
    chk("unit_fault_o", {25'h0, exp_fault}, {25'h0, unit_fault_o});
  endtask : req

  initial begin
    {wb_we_i, wb_cyc_i, wb_stb_i, sleep_i, deep_sleep_i} = '0;
    {wb_adr_i, wb_dat_i, wb_sel_i, unit_req_i} = '0;
    run_gate_group1_i   = 32'h0100_0000;
    sleep_gate_group1_i = 32'h0001_0000;
    rst_i = 1'b1;
    err_count = 0;
    n_compared = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 12'h124, 32'h0, 4'hf);
    chk("gate reset", 32'h0, rd);
    wb(1'b1, 12'h124, 32'hffff_ffff, 4'hf);
    wb(1'b0, 12'h124, 32'h0, 4'hf);
    chk("gate rw mask", 32'h0107_0013, rd);
    wb(1'b1, 12'h124, 32'h0, 4'h1);
    wb(1'b0, 12'h124, 32'h0, 4'hf);
    chk("gate byte0 write", 32'h0107_0000, rd);
    wb(1'b0, 12'h200, 32'h0, 4'hf);
    chk("unmapped read", 32'h0, rd);
    wb(1'b1, 12'h124, 32'h0000_0010, 4'hf);
    // Auto gating off: run enables apply even in deep-sleep
    deep_sleep_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("auto off", 32'h40, {25'h0, unit_clk_en_o});
    wb(1'b1, 12'h060, 32'h0800_0000, 4'hf);
    for (int m = 0; m < 4; m++) begin
      sleep_i      <= mode_tab[m][1];
      deep_sleep_i <= mode_tab[m][0];
      repeat (3) @(posedge clk_i);
      chk("mode enables", {25'h0, exp_tab[m]}, {25'h0, unit_clk_en_o});
    end
    wb(1'b0, 12'h138, 32'h0, 4'hf);
    chk("effective enables", 32'h0000_0010, rd);
    req(2, 7'h00);
    req(0, 7'h01);
    wb(1'b0, 12'h130, 32'h0, 4'hf);
    chk("fault status", 32'h1, rd);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    wb(1'b1, 12'h134, 32'h1, 4'hf);
    repeat (2) @(posedge clk_i);
    chk("irq unmasked", 32'h1, {31'h0, irq_o});
    wb(1'b1, 12'h130, 32'h1, 4'hf);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    // Read-modify-write keeps whatever the reserved bits hold
    wb(1'b0, 12'h124, 32'h0, 4'hf);
    wb(1'b1, 12'h124, rd | 32'h0107_0003, 4'hf);
    repeat (3) @(posedge clk_i);
    chk("all units on", 32'h7f, {25'h0, unit_clk_en_o});
    req(6, 7'h00);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 12'h124, 32'h0, 4'hf);
    chk("gate second reset", 32'h0, rd);
    // Auto gating is off again after reset, so timer two follows the run enables
    req(5, 7'h20);
    wb(1'b0, 12'h130, 32'h0, 4'hf);
    chk("timer two fault status", 32'h0004_0000, rd);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
